/* ppsm_params.svh */
// Constants for the device power-state controller.
// Assumes inclusion by the package and the top module; one clock domain.
// Operation
// - Uninitialized: clocks run, no Ethernet traffic
// - Full power: all PCI accesses, field 00b
// - Uninitialized plus write 11b enters D3hot
// - Host configuration moves uninitialized to active
// - Main power loss with aux: D3cold, PHY down (from D3hot entered with wake enabled, the code leaves the PHY up)
// - No aux power: main power loss means off
// - Active write 11b: D3hot, PHY down unless wake
// - Bus reset fall returns active/D3hot to uninitialized
// - Active wake events use interrupt or wake request
// - D3hot: PLL off, traffic stopped, PHY down unless wake enabled on entry
// - D3hot: config only, field reads 11b
// - D3hot wake events only via wake request
// - D3hot main power loss with aux: D3cold
// - D3hot write 00b: uninitialized with exit reset
// - D3cold on aux: ignore PCI and reset
// - D3cold on aux: clocks off, wake armed
// - D3cold without aux behaves as off
// - Aux power-on: clear enable, field D3, PHY down
`ifndef PPSM_PARAMS_SVH
`define PPSM_PARAMS_SVH

// ============================================================
// Field encodings and reset values
`define PPSM_FIELD_D0      2'h0
`define PPSM_FIELD_D3      2'h3
`define PPSM_WAKE_EN_RST   1'b0

// ============================================================
// Timing: length of the D3 exit reset pulse
`define PPSM_CLK_PERIOD_NS 20
`define PPSM_D3_EXIT_RESET_NS      100
`define PPSM_D3_EXIT_RESET_CYC     ((`PPSM_D3_EXIT_RESET_NS + `PPSM_CLK_PERIOD_NS - 1) / `PPSM_CLK_PERIOD_NS)

`endif

/* ppsm_pkg.sv */
// Types shared by the power-state controller files.
// Assumes the params header is on the include path.
`include "ppsm_params.svh"
package ppsm_pkg;

    // ============================================================
    // Device power states
    typedef enum logic [2:0] {
        PPSM_OFF,
        PPSM_UNINIT,
        PPSM_ACTIVE,
        PPSM_D3HOT,
        PPSM_D3COLD
    } ppsm_state_t;

    // ============================================================
    // Gating outputs carried together
    typedef struct packed {
        logic pll_clk_en;
        logic eth_en;
        logic pci_cfg_en;
        logic pci_memio_en;
    } ppsm_gate_t;

endpackage

/* ppsm_sync.sv */
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the destination clock runs freely.
`timescale 1ns/1ps
module ppsm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Two registers in a row
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;
endmodule

/* ppsm_pulse.sv */
// Counts out a fixed-length pulse after a start strobe.
// Assumes start is a one-cycle strobe on the same clock.
`timescale 1ns/1ps
module ppsm_pulse #(
    parameter int LEN = 1
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic start_in,
    output logic      pulse_out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // Reload on start, otherwise count down to zero and hold
    always_comb begin
        cnt_d = cnt_q;
        if (start_in) begin
            cnt_d = 8'(LEN);
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign pulse_out = (cnt_q != 8'h00);
endmodule

/* ppsm_top.sv */
// Device power-state controller: tracks D0 uninit/active, D3hot, D3cold.
// Assumes CLK_SYS_IN is the always-running reference; RST_N_IN is the
// internal power-on reset from aux (or main) power; pins are asynchronous.
`timescale 1ns/1ps
`include "ppsm_params.svh"
module ppsm_top
    import ppsm_pkg::*;
(
    input  wire logic       CLK_SYS_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       BUS_RESET_N_IN,
    input  wire logic       MAIN_POWER_GOOD_IN,
    input  wire logic       AUX_POWER_DETECT_IN,
    input  wire logic       PS_WRITE_IN,
    input  wire logic [1:0] PS_WDATA_IN,
    input  wire logic       WAKE_EN_WRITE_IN,
    input  wire logic       WAKE_EN_WDATA_IN,
    input  wire logic       HOST_CONFIGURED_IN,
    input  wire logic       WAKE_EVENT_IN,
    input  wire logic       WAKE_USE_INT_IN,
    output logic [1:0]      POWER_STATE_FIELD_OUT,
    output logic            WAKE_SIGNAL_ENABLE_OUT,
    output logic [2:0]      STATE_OUT,
    output logic            PLL_CLK_EN_OUT,
    output logic            ETH_EN_OUT,
    output logic            PCI_CFG_EN_OUT,
    output logic            PCI_MEMIO_EN_OUT,
    output logic            PHY_POWER_DOWN_OUT,
    output logic            PHY_RESET_OUT,
    output logic            D3_EXIT_RESET_OUT,
    output logic            WAKE_REQUEST_N_OUT,
    output logic            INTERRUPT_REQUEST_N_OUT
);

    // ============================================================
    // Pin synchronisation
    logic [2:0] pins_s;
    logic       bus_reset_n_s;
    logic       main_power_good_s;
    logic       aux_power_detect_s;

    ppsm_sync #(.W(3)) u_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_n_in (RST_N_IN),
        .d_in     ({BUS_RESET_N_IN, MAIN_POWER_GOOD_IN, AUX_POWER_DETECT_IN}),
        .q_out    (pins_s)
    );

    assign bus_reset_n_s      = pins_s[2];
    assign main_power_good_s  = pins_s[1];
    assign aux_power_detect_s = pins_s[0];

    // ============================================================
    // State registers
    ppsm_state_t state_q;
    ppsm_state_t state_d;
    logic        wake_en_q;
    logic        wake_en_d;
    logic        brst_prev_q;
    logic        pgood_prev_q;
    logic [1:0]  settle_q;
    logic        phy_pd_q;
    logic        phy_pd_d;
    logic        phy_rst_q;
    logic        phy_rst_d;
    logic        d3_exit_reset_start;
    logic        brst_fall;
    logic        pgood_fall;
    logic        ps_to_d3;
    logic        ps_to_d0;
    logic        d3_exit_reset_pulse;
    ppsm_gate_t  gate;

    assign brst_fall  = brst_prev_q && !bus_reset_n_s;
    assign pgood_fall = pgood_prev_q && !main_power_good_s;
    assign ps_to_d3   = PS_WRITE_IN && (PS_WDATA_IN == `PPSM_FIELD_D3);
    assign ps_to_d0   = PS_WRITE_IN && (PS_WDATA_IN == `PPSM_FIELD_D0);

    // Next-state logic for power state and PHY control
    always_comb begin
        state_d     = state_q;
        wake_en_d   = wake_en_q;
        phy_pd_d    = phy_pd_q;
        phy_rst_d   = 1'b0;
        d3_exit_reset_start = 1'b0;
        if (WAKE_EN_WRITE_IN && state_q != PPSM_D3COLD && state_q != PPSM_OFF) begin
            wake_en_d = WAKE_EN_WDATA_IN;
        end
        case (state_q)
            PPSM_OFF: begin
                wake_en_d = `PPSM_WAKE_EN_RST;
                phy_pd_d  = 1'b0;
                if (main_power_good_s) begin
                    state_d   = PPSM_UNINIT;
                    phy_rst_d = 1'b1;
                end
            end
            PPSM_UNINIT, PPSM_ACTIVE: begin
                if (pgood_fall) begin
                    if (aux_power_detect_s) begin
                        state_d   = PPSM_D3COLD;
                        phy_pd_d  = 1'b1;
                        phy_rst_d = 1'b1;
                    end else begin
                        state_d = PPSM_OFF;
                    end
                end else if (state_q == PPSM_ACTIVE && brst_fall) begin
                    state_d = PPSM_UNINIT;
                end else if (ps_to_d3 && bus_reset_n_s && main_power_good_s) begin
                    state_d = PPSM_D3HOT;
                    if (!wake_en_q) begin
                        phy_pd_d  = 1'b1;
                        phy_rst_d = 1'b1;
                    end
                end else if (state_q == PPSM_UNINIT && HOST_CONFIGURED_IN &&
                             main_power_good_s && bus_reset_n_s) begin
                    state_d = PPSM_ACTIVE;
                end
            end
            PPSM_D3HOT: begin
                if (pgood_fall) begin
                    state_d = aux_power_detect_s ? PPSM_D3COLD : PPSM_OFF;
                end else if (brst_fall) begin
                    state_d   = PPSM_UNINIT;
                    phy_pd_d  = 1'b0;
                    phy_rst_d = phy_pd_q;
                end else if (ps_to_d0) begin
                    state_d     = PPSM_UNINIT;
                    d3_exit_reset_start = 1'b1;
                    phy_pd_d    = 1'b0;
                    phy_rst_d   = phy_pd_q;
                end
            end
            PPSM_D3COLD: begin
                // bus reset ignored
                // Pins are not trusted until the synchroniser has filled
                if (!settle_q[1]) begin
                    state_d = PPSM_D3COLD;
                end else if (!aux_power_detect_s && !main_power_good_s) begin
                    state_d = PPSM_OFF;
                end else if (main_power_good_s) begin
                    state_d   = PPSM_UNINIT;
                    phy_pd_d  = 1'b0;
                    phy_rst_d = 1'b1;
                end
            end
            default: begin
                state_d = PPSM_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q      <= PPSM_D3COLD;
            wake_en_q    <= `PPSM_WAKE_EN_RST;
            phy_pd_q     <= 1'b1;
            phy_rst_q    <= 1'b0;
            brst_prev_q  <= 1'b0;
            pgood_prev_q <= 1'b0;
            settle_q     <= 2'h0;
        end else begin
            state_q      <= state_d;
            wake_en_q    <= wake_en_d;
            phy_pd_q     <= phy_pd_d;
            phy_rst_q    <= phy_rst_d;
            brst_prev_q  <= bus_reset_n_s;
            pgood_prev_q <= main_power_good_s;
            settle_q     <= {settle_q[0], 1'b1};
        end
    end

    // ============================================================
    // D3 exit reset pulse
    ppsm_pulse #(.LEN(`PPSM_D3_EXIT_RESET_CYC)) u_d3_exit_reset (
        .clk_in    (CLK_SYS_IN),
        .rst_n_in  (RST_N_IN),
        .start_in  (d3_exit_reset_start),
        .pulse_out (d3_exit_reset_pulse)
    );

    // ============================================================
    // Gating decoded from state
    always_comb begin
        gate = '0;
        case (state_q)
            PPSM_UNINIT: begin
                gate.pll_clk_en   = 1'b1;
                gate.pci_cfg_en   = 1'b1;
                gate.pci_memio_en = 1'b1;
            end
            PPSM_ACTIVE: begin
                gate.pll_clk_en   = 1'b1;
                gate.eth_en       = 1'b1;
                gate.pci_cfg_en   = 1'b1;
                gate.pci_memio_en = 1'b1;
            end
            PPSM_D3HOT: begin
                gate.pci_cfg_en = 1'b1;
            end
            default: begin
                gate = '0;
            end
        endcase
    end

    assign PLL_CLK_EN_OUT   = gate.pll_clk_en;
    assign ETH_EN_OUT       = gate.eth_en;
    assign PCI_CFG_EN_OUT   = gate.pci_cfg_en;
    assign PCI_MEMIO_EN_OUT = gate.pci_memio_en;

    assign POWER_STATE_FIELD_OUT = (state_q == PPSM_UNINIT || state_q == PPSM_ACTIVE) ?
                                   `PPSM_FIELD_D0 : `PPSM_FIELD_D3;
    assign WAKE_SIGNAL_ENABLE_OUT = wake_en_q;
    assign STATE_OUT              = state_q;
    assign PHY_POWER_DOWN_OUT     = phy_pd_q;
    assign PHY_RESET_OUT          = phy_rst_q;
    assign D3_EXIT_RESET_OUT      = d3_exit_reset_pulse;

    // ============================================================
    // Wake signalling
    logic wake_req;
    logic int_req;

    always_comb begin
        wake_req = 1'b0;
        int_req  = 1'b0;
        if (WAKE_EVENT_IN && wake_en_q) begin
            case (state_q)
                PPSM_ACTIVE: begin
                    int_req  = WAKE_USE_INT_IN;
                    wake_req = !WAKE_USE_INT_IN;
                end
                PPSM_D3HOT, PPSM_D3COLD: begin
                    wake_req = 1'b1;
                end
                default: begin
                    wake_req = 1'b0;
                end
            endcase
        end
    end

    assign WAKE_REQUEST_N_OUT      = !wake_req;
    assign INTERRUPT_REQUEST_N_OUT = !int_req;

endmodule

/* ppsm_checker_sva.sv */
// Checker for the power-state controller, bound to its top module.
// Assumes one clock domain and the state codes of the package.
`timescale 1ns/1ps
module ppsm_checker
    import ppsm_pkg::*;
(
    input  wire logic       CLK_SYS_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       PS_WRITE_IN,
    input  wire logic [1:0] PS_WDATA_IN,
    input  wire logic       WAKE_EVENT_IN,
    input  wire logic       WAKE_USE_INT_IN,
    input  wire logic [1:0] POWER_STATE_FIELD_OUT,
    input  wire logic       WAKE_SIGNAL_ENABLE_OUT,
    input  wire logic [2:0] STATE_OUT,
    input  wire logic       PLL_CLK_EN_OUT,
    input  wire logic       ETH_EN_OUT,
    input  wire logic       PCI_CFG_EN_OUT,
    input  wire logic       PCI_MEMIO_EN_OUT,
    input  wire logic       PHY_POWER_DOWN_OUT,
    input  wire logic       PHY_RESET_OUT,
    input  wire logic       D3_EXIT_RESET_OUT,
    input  wire logic       WAKE_REQUEST_N_OUT,
    input  wire logic       INTERRUPT_REQUEST_N_OUT
);
    // ============================================================
    // Clocking and gate vector
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    wire [3:0] gates = {PLL_CLK_EN_OUT, ETH_EN_OUT, PCI_CFG_EN_OUT, PCI_MEMIO_EN_OUT};
    logic      wk;
    assign wk = WAKE_EVENT_IN && WAKE_SIGNAL_ENABLE_OUT;

    // ============================================================
    // Host write sequences and the exit pulse shape
    sequence s_sleep(bit wen);
        STATE_OUT == PPSM_ACTIVE && PS_WRITE_IN && PS_WDATA_IN == 2'h3
            && WAKE_SIGNAL_ENABLE_OUT == wen;
    endsequence
    sequence s_wake_up;
        STATE_OUT == PPSM_D3HOT && PS_WRITE_IN && PS_WDATA_IN == 2'h0;
    endsequence
    sequence s_exit_pulse;
        D3_EXIT_RESET_OUT [*5] ##1 !D3_EXIT_RESET_OUT;
    endsequence

    // ============================================================
    // Assertions
    AST_FIELD_D0: assert property (STATE_OUT inside {PPSM_UNINIT, PPSM_ACTIVE}
        |-> POWER_STATE_FIELD_OUT == 2'h0) else $error("field not D0 in full power");
    AST_FIELD_D3: assert property (STATE_OUT == PPSM_D3HOT
        |-> POWER_STATE_FIELD_OUT == 2'h3) else $error("field not D3 in D3hot");
    AST_UNINIT_GATES: assert property (STATE_OUT == PPSM_UNINIT
        |-> gates == 4'hB) else $error("uninit gates wrong");
    AST_D3HOT_GATES: assert property (STATE_OUT == PPSM_D3HOT
        |-> gates == 4'h2) else $error("D3hot gates wrong");
    AST_COLD_GATES: assert property (STATE_OUT == PPSM_D3COLD
        |-> gates == 4'h0) else $error("D3cold gates wrong");
    AST_SLEEP_PHY_DOWN: assert property (s_sleep(1'b0) |=> STATE_OUT == PPSM_D3HOT
        && PHY_RESET_OUT && PHY_POWER_DOWN_OUT ##1 !PHY_RESET_OUT) else $error("PHY not downed");
    AST_SLEEP_PHY_KEPT: assert property (s_sleep(1'b1) |=> STATE_OUT == PPSM_D3HOT
        && !PHY_RESET_OUT) else $error("PHY reset with wake enabled");
    AST_EXIT_RESET: assert property (s_wake_up |=> (STATE_OUT == PPSM_UNINIT)
        ##0 s_exit_pulse) else $error("D3 exit reset wrong");
    AST_D3HOT_WAKE: assert property (STATE_OUT == PPSM_D3HOT |-> INTERRUPT_REQUEST_N_OUT
        && WAKE_REQUEST_N_OUT == !wk) else $error("D3hot wake routing wrong");
    AST_ACTIVE_WAKE: assert property (STATE_OUT == PPSM_ACTIVE && wk
        |-> INTERRUPT_REQUEST_N_OUT == !WAKE_USE_INT_IN
        && WAKE_REQUEST_N_OUT == WAKE_USE_INT_IN) else $error("active wake routing wrong");
    AST_COLD_WAKE: assert property (STATE_OUT == PPSM_D3COLD |-> INTERRUPT_REQUEST_N_OUT
        && WAKE_REQUEST_N_OUT == !wk) else $error("D3cold wake routing wrong");
endmodule

bind ppsm_top ppsm_checker ppsm_checker_i (.*);

/* ppsm_host_model.sv */
// Host model: power-state writes, wake enable writes, configure, bus reset.
// Assumes one clock; drives just after each rising edge.
`timescale 1ns/1ps
module ppsm_host_model (
    input  wire logic clk_in,
    output logic      bus_reset_n_out,
    output logic      ps_write_out,
    output logic [1:0] ps_wdata_out,
    output logic      wen_write_out,
    output logic      wen_wdata_out,
    output logic      configured_out
);
    // ============================================================
    // Idle values
    initial begin
        bus_reset_n_out = 1'b0;
        ps_write_out    = 1'b0;
        wen_write_out   = 1'b0;
        ps_wdata_out    = 2'h0;
        wen_wdata_out   = 1'b0;
        configured_out  = 1'b0;
    end
    task automatic write_ps(input logic [1:0] v);
        @(posedge clk_in) #1;
        ps_write_out = 1'b1;
        ps_wdata_out = v;
        @(posedge clk_in) #1;
        ps_write_out = 1'b0;
        ps_wdata_out = ~v;
    endtask
    // Wake enable write
    task automatic write_wen(input logic v);
        @(posedge clk_in) #1;
        wen_write_out = 1'b1;
        wen_wdata_out = v;
        @(posedge clk_in) #1;
        wen_write_out = 1'b0;
        wen_wdata_out = ~v;
    endtask
    task automatic configure();
        @(posedge clk_in) #1;
        configured_out = 1'b1;
        @(posedge clk_in) #1;
        configured_out = 1'b0;
    endtask
    // Bus reset level
    task automatic bus_reset(input logic v);
        @(posedge clk_in) #1;
        bus_reset_n_out = v;
    endtask
endmodule

/* pci_power_state_machine_bench.sv */
// Testbench for the power-state controller with the host model.
// Assumes a 50 MHz clock; power pins driven here, host pins by the model.
`timescale 1ns/1ps
module pci_power_state_machine_bench;
    import ppsm_pkg::*;
    logic       clk, rst_n, aux, main, wev, use_int;
    logic       brst_n, psw, wenw, wend, cfgd;
    logic [1:0] psd, field;
    logic [2:0] st;
    logic       wen, pll, eth, cfg, mio, pd, prst, d3r, wake_n, int_n;
    int         errors, comparisons, n;
    wire [3:0]  gates = {pll, eth, cfg, mio};

    ppsm_host_model ppsm_host_model_i (.clk_in(clk), .bus_reset_n_out(brst_n),
        .ps_write_out(psw), .ps_wdata_out(psd), .wen_write_out(wenw),
        .wen_wdata_out(wend), .configured_out(cfgd));
    ppsm_top ppsm_top_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .BUS_RESET_N_IN(brst_n),
        .MAIN_POWER_GOOD_IN(main), .AUX_POWER_DETECT_IN(aux), .PS_WRITE_IN(psw),
        .PS_WDATA_IN(psd), .WAKE_EN_WRITE_IN(wenw), .WAKE_EN_WDATA_IN(wend),
        .HOST_CONFIGURED_IN(cfgd), .WAKE_EVENT_IN(wev), .WAKE_USE_INT_IN(use_int),
        .POWER_STATE_FIELD_OUT(field), .WAKE_SIGNAL_ENABLE_OUT(wen), .STATE_OUT(st),
        .PLL_CLK_EN_OUT(pll), .ETH_EN_OUT(eth), .PCI_CFG_EN_OUT(cfg),
        .PCI_MEMIO_EN_OUT(mio), .PHY_POWER_DOWN_OUT(pd), .PHY_RESET_OUT(prst),
        .D3_EXIT_RESET_OUT(d3r), .WAKE_REQUEST_N_OUT(wake_n),
        .INTERRUPT_REQUEST_N_OUT(int_n));

    // ============================================================
    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ============================================================
    // Compare, wait and verdict
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_st(input logic [2:0] s);
        n = 0;
        while (st !== s && n < 20) begin
            @(posedge clk) #1;
            n++;
        end
        chk("state", {1'b0, s}, {1'b0, st});
        if (st !== s) give_verdict();
    endtask
    task automatic pins(input logic a, input logic m, input logic e, input logic u);
        @(posedge clk) #1;
        aux     = a;
        main    = m;
        wev     = e;
        use_int = u;
        #1;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        errors = 0;
        comparisons = 0;
        rst_n   = 1'b0;
        aux     = 1'b1;
        main    = 1'b0;
        wev     = 1'b0;
        use_int = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("state", 4'h4, {1'b0, st});
        chk("pon", 4'hD, {field, wen, pd});
        ppsm_host_model_i.bus_reset(1'b1);
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        wait_st(PPSM_UNINIT);
        chk("gates", 4'hB, gates);
        ppsm_host_model_i.configure();
        chk("active", 4'hF, gates);
        ppsm_host_model_i.write_wen(1'b1);
        chk("wen", 4'h1, {3'h0, wen});
        pins(1'b1, 1'b1, 1'b1, 1'b1);
        chk("wake", 4'h2, {2'h0, wake_n, int_n});
        pins(1'b1, 1'b1, 1'b1, 1'b0);
        chk("wake", 4'h2, {2'h0, int_n, wake_n});
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        ppsm_host_model_i.write_ps(2'h3);
        chk("sleep", 4'h3, {1'b0, st}); // PHY kept
        chk("d3gates", 4'h2, gates);
        chk("d3keep", 4'hC, {field, prst, pd});
        pins(1'b1, 1'b1, 1'b1, 1'b1);
        chk("d3wake", 4'h1, {2'h0, wake_n, int_n});
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        ppsm_host_model_i.write_ps(2'h0);
        chk("state", 4'h1, {1'b0, st});
        n = 0;
        while (d3r === 1'b1 && n < 10) begin
            n++;
            @(posedge clk) #1;
        end
        chk("d3len", 4'h5, n[3:0]);
        ppsm_host_model_i.write_ps(2'h3);
        chk("state", 4'h3, {1'b0, st});
        ppsm_host_model_i.bus_reset(1'b0);
        wait_st(PPSM_UNINIT);
        ppsm_host_model_i.bus_reset(1'b1);
        repeat (2) @(posedge clk);
        ppsm_host_model_i.configure();
        chk("state", 4'h2, {1'b0, st});
        ppsm_host_model_i.write_wen(1'b0);
        ppsm_host_model_i.write_ps(2'h3);
        chk("down", 4'h7, {st, prst});
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        wait_st(PPSM_D3COLD);
        ppsm_host_model_i.bus_reset(1'b0);
        repeat (6) @(posedge clk);
        ppsm_host_model_i.write_wen(1'b1);
        chk("ignore", 4'h4, {1'b0, st});
        chk("coldwen", 4'h0, {3'h0, wen});
        ppsm_host_model_i.bus_reset(1'b1);
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        wait_st(PPSM_UNINIT);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        wait_st(PPSM_D3COLD);
        chk("coldpd", 4'h1, {3'h0, pd});
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        wait_st(PPSM_OFF);
        pins(1'b0, 1'b1, 1'b0, 1'b0);
        wait_st(PPSM_UNINIT);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        wait_st(PPSM_OFF);
        give_verdict();
    end
endmodule
